// ---- sop_consts.vh ----
// Constants for the sixteen channel output port
// How it works
// - Sixteen independent output channels, each with its own indicator.
// - Two-byte image at offset zero; byte 0 drives channels 0-7, byte 1 channels 8-15.
// - No input bytes; reads of input data return nothing.
// - Channel indicator lit while its channel is one, dark while zero.
// - Overload raises diagnostic interrupt only when the parameter enables it.
// - Red indicator steady while any output is overloaded, regardless of enable.
// - Green indicators steady while backplane works and no fault is reported.
// - Red indicator steady while an overload is reported; an invalid configuration alone blinks it.
// - Invalid configuration blinks red indicator at one hertz.
// - Backplane failure blinks green indicators at one hertz.
// - When the interrupt cause disappears, a going event is signalled automatically.
// - Diagnostic byte 0 bit 4 set while any output is overloaded.
`ifndef SOP_CONSTS_VH
`define SOP_CONSTS_VH
`define SOP_IMG_OFFSET    1'h0
`define SOP_BYTE0_LSB     0
`define SOP_BYTE1_LSB     8
`define SOP_IMG_RESET     16'h0000
`define SOP_DIAG_RESET    8'h00
`define SOP_IN_EMPTY      8'h00
`define SOP_BLINK_RESET   1'h0
`define SOP_DIAG_OVL_BIT  4
`define SOP_DIAG_CFG_BIT  7
`define SOP_DIAG_EXT_BIT  2
`define SOP_CLK_HZ        100000000
`define SOP_BLINK_HZ      1
`define SOP_HALF_CYCLES   (`SOP_CLK_HZ / (2 * `SOP_BLINK_HZ))
`endif

// ---- sop_output_port.v ----
// Sixteen channel output port core
`timescale 1ns/1ns
`include "sop_consts.vh"

// ----------------------------------------
// Two-stage synchroniser
// ----------------------------------------
module sop_sync2 #(
	parameter W = 1
) (
	input  wire           clk,
	input  wire           rst_n,
	input  wire [W-1:0]   d,
	output wire [W-1:0]   q
);

// Only the second stage is read, so a metastable first stage stays local
reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		s1_reg <= {W{1'h0}};
		s2_reg <= {W{1'h0}};
	end else begin
		s1_reg <= d;
		s2_reg <= s1_reg;
	end
end

assign q = s2_reg;

endmodule // sop_sync2

// ----------------------------------------
// Half-period tick divider
// ----------------------------------------
module sop_tick_div #(
	parameter HALF_CYCLES = `SOP_HALF_CYCLES,
	parameter CNT_W       = 32
) (
	input  wire   clk,
	input  wire   rst_n,
	output wire   tick
);

// Counter must be wide enough to hold HALF_CYCLES - 1
localparam [CNT_W-1:0] LAST_CNT = HALF_CYCLES - 1;
localparam [CNT_W-1:0] ONE_CNT  = 1;

reg  [CNT_W-1:0] cnt_reg;
reg              tick_reg;
wire             wrap_w = (cnt_reg == LAST_CNT);

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt_reg  <= {CNT_W{1'h0}};
		tick_reg <= 1'h0;
	end else begin
		tick_reg <= wrap_w;
		if (wrap_w)
			cnt_reg <= {CNT_W{1'h0}};
		else
			cnt_reg <= cnt_reg + ONE_CNT;
	end
end

assign tick = tick_reg;

endmodule // sop_tick_div

// ----------------------------------------
// Image byte lane
// ----------------------------------------
module sop_byte_lane #(
	parameter W = 8
) (
	input  wire [W-1:0]   wdata,
	input  wire [W-1:0]   cur,
	input  wire           load,
	output wire [W-1:0]   nxt
);

// Disabled lanes keep their value, so a one-byte write leaves the other alone
assign nxt = load ? wdata : cur;

endmodule // sop_byte_lane

module sop_output_port #(
	parameter NCH         = 16,
	parameter HALF_CYCLES = `SOP_HALF_CYCLES
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             img_wr,
	input  wire             img_addr,
	input  wire [1:0]       img_be,
	input  wire [15:0]      img_wdata,
	input  wire             in_rd,
	output wire             in_valid,
	output wire [7:0]       in_rdata,
	input  wire [NCH-1:0]   overload_pin,
	input  wire             cfg_invalid,
	input  wire             bus_ok,
	input  wire             diag_irq_en,
	output reg  [NCH-1:0]   channel_out,
	output reg  [NCH-1:0]   channel_led,
	output reg              led_green,
	output reg              led_red,
	output reg  [7:0]       diag_byte0,
	output reg              diag_incoming,
	output reg              diag_going,
	output reg              diag_active
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// Overload, config and bus status come from outside, so two stages first
wire [NCH-1:0] ovl_sync_w;
wire [1:0]     st_sync_w;

sop_sync2 #(
	.W(NCH)
) i_ovl_sync (
	.clk   (clk),
	.rst_n (rst_n),
	.d     (overload_pin),
	.q     (ovl_sync_w)
);

sop_sync2 #(
	.W(2)
) i_st_sync (
	.clk   (clk),
	.rst_n (rst_n),
	.d     ({bus_ok, cfg_invalid}),
	.q     (st_sync_w)
);

wire any_ovl = |ovl_sync_w;
wire cfg_bad = st_sync_w[0];
wire link_ok = st_sync_w[1];

// ----------------------------------------
// Output image
// ----------------------------------------
// Writes to any other offset are dropped, not wrapped onto the image
wire           img_hit_w = img_wr && (img_addr == `SOP_IMG_OFFSET);
wire [NCH-1:0] img_next_w;

sop_byte_lane #(
	.W(8)
) i_lane0 (
	.wdata (img_wdata[`SOP_BYTE0_LSB +: 8]),
	.cur   (channel_out[`SOP_BYTE0_LSB +: 8]),
	.load  (img_hit_w && img_be[0]),
	.nxt   (img_next_w[`SOP_BYTE0_LSB +: 8])
);

sop_byte_lane #(
	.W(8)
) i_lane1 (
	.wdata (img_wdata[`SOP_BYTE1_LSB +: 8]),
	.cur   (channel_out[`SOP_BYTE1_LSB +: 8]),
	.load  (img_hit_w && img_be[1]),
	.nxt   (img_next_w[`SOP_BYTE1_LSB +: 8])
);

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		channel_out <= `SOP_IMG_RESET;
		channel_led <= `SOP_IMG_RESET;
	end else begin
		channel_out <= img_next_w;
		// Indicators load with the image, so they never lag the pins
		channel_led <= img_next_w;
	end
end

// ----------------------------------------
// Input area
// ----------------------------------------
// No input bytes: a read is accepted but never returns data
reg [7:0] in_rdata_reg;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n)
		in_rdata_reg <= `SOP_IN_EMPTY;
	else if (in_rd)
		in_rdata_reg <= `SOP_IN_EMPTY;
end

assign in_valid = 1'h0;
assign in_rdata = in_rdata_reg;

// ----------------------------------------
// One hertz blink divider
// ----------------------------------------
// Divider gives one pulse per half period; the phase flop toggles on it
wire half_tick_w;
reg  blink_reg;

sop_tick_div #(
	.HALF_CYCLES (HALF_CYCLES),
	.CNT_W       (32)
) i_blink_div (
	.clk   (clk),
	.rst_n (rst_n),
	.tick  (half_tick_w)
);

always @(posedge clk or negedge rst_n) begin
	if (!rst_n)
		blink_reg <= `SOP_BLINK_RESET;
	else if (half_tick_w)
		blink_reg <= ~blink_reg;
end

// ----------------------------------------
// Status indicators and diagnostics
// ----------------------------------------
// Overload wins over config blink on red: steady beats blinking
reg       ovl_d_reg;
reg       green_next;
reg       red_next;
reg [7:0] diag_next;
wire      ovl_rise_w = any_ovl && !ovl_d_reg;

always @* begin
	if (!link_ok)
		green_next = blink_reg;
	else
		green_next = !(any_ovl || cfg_bad);
end

always @* begin
	if (any_ovl)
		red_next = 1'h1;
	else if (cfg_bad)
		red_next = blink_reg;
	else
		red_next = 1'h0;
end

// Overload also counts as an external fault in the record
always @* begin
	diag_next                    = `SOP_DIAG_RESET;
	diag_next[`SOP_DIAG_OVL_BIT] = any_ovl;
	diag_next[`SOP_DIAG_EXT_BIT] = any_ovl;
	diag_next[`SOP_DIAG_CFG_BIT] = cfg_bad;
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		led_green     <= 1'h0;
		led_red       <= 1'h0;
		diag_byte0    <= `SOP_DIAG_RESET;
		diag_incoming <= 1'h0;
		diag_going    <= 1'h0;
		diag_active   <= 1'h0;
		ovl_d_reg     <= 1'h0;
	end else begin
		led_green     <= green_next;
		led_red       <= red_next;
		diag_byte0    <= diag_next;
		ovl_d_reg     <= any_ovl;
		diag_incoming <= diag_irq_en && ovl_rise_w;
		// Going follows only an interrupt that was raised
		diag_going    <= diag_active && !any_ovl;
		if (diag_irq_en && ovl_rise_w)
			diag_active <= 1'h1;
		else if (!any_ovl)
			diag_active <= 1'h0;
	end
end

endmodule // sop_output_port

// ---- sop_output_port_sva.sv ----
// Checker for the output port
`timescale 1ns/1ns
module sop_output_port_sva(input wire clk,rst_n,img_wr,img_addr,in_valid,diag_irq_en,
	input wire [1:0] img_be,input wire [15:0] img_wdata,overload_pin,channel_out,channel_led,
	input wire [7:0] in_rdata,diag_byte0,input wire led_red,diag_incoming,diag_going,diag_active);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
led_mirror_a: assert property (channel_led == channel_out) else $error("led mismatch");
no_input_a: assert property (!in_valid && in_rdata == 8'h00) else $error("input data");
low_byte_a: assert property (img_wr && !img_addr && img_be[0] |=>
	channel_out[7:0] == $past(img_wdata[7:0])) else $error("low byte");
high_byte_a: assert property (img_wr && !img_addr && img_be[1] |=>
	channel_out[15:8] == $past(img_wdata[15:8])) else $error("high byte");
image_hold_a: assert property (!(img_wr && !img_addr) |=> $stable(channel_out))
	else $error("image moved");
ovl_set_a: assert property ((overload_pin != 16'h0)[*4] |-> diag_byte0[4] && led_red)
	else $error("overload unseen");
ovl_clr_a: assert property ((overload_pin == 16'h0)[*4] |-> !diag_byte0[4])
	else $error("overload stuck");
red_err_a: assert property (diag_byte0[4] |-> led_red) else $error("red dark");
irq_gate_a: assert property (diag_incoming |-> $past(diag_irq_en)) else $error("irq off");
irq_raise_a: assert property ($rose(diag_active) |-> diag_incoming) else $error("no irq");
going_pulse_a: assert property (diag_going |=> !diag_going) else $error("going long");
going_evt_a: assert property ($fell(diag_active) |-> diag_going) else $error("no going");
endmodule // sop_output_port_sva
bind sop_output_port sop_output_port_sva i_sva(.*);

// ---- sop_host_model.sv ----
// Host model writing the output image
`timescale 1ns/1ns
module sop_host_model(input wire clk,output logic img_wr,img_addr,output logic [1:0] img_be,
	output logic [15:0] img_wdata);
initial {img_wr,img_addr,img_be,img_wdata} = 20'h0;
// Data inverted once released, so a stale value cannot pass
task wr(input logic a,input logic [1:0] b,input logic [15:0] d);
	@(negedge clk) {img_wr,img_addr,img_be,img_wdata} = {1'h1,a,b,d};
	@(negedge clk) {img_wr,img_wdata} = {1'h0,~d};
endtask
endmodule // sop_host_model

// ---- sixteen_channel_output_port_tb.sv ----
// Testbench for the output port
`timescale 1ns/1ns
module sixteen_channel_output_port_tb;
logic clk=0,rst_n=0,in_rd=0,cfg_invalid=0,bus_ok=1,diag_irq_en=1,img_wr,img_addr,in_valid;
logic led_green,led_red,inc,going,act;
logic [1:0] img_be;
logic [15:0] img_wdata,overload_pin=16'h0,channel_out,channel_led;
logic [7:0] in_rdata,diag_byte0;
int errors=0,compares=0,n,m;
always #5 clk=~clk;
sop_host_model i_host(.clk(clk),.img_wr(img_wr),.img_addr(img_addr),.img_be(img_be),
	.img_wdata(img_wdata));
sop_output_port #(.HALF_CYCLES(4)) i_dut(.clk(clk),.rst_n(rst_n),.img_wr(img_wr),
	.img_addr(img_addr),.img_be(img_be),.img_wdata(img_wdata),.in_rd(in_rd),
	.in_valid(in_valid),.in_rdata(in_rdata),.overload_pin(overload_pin),
	.cfg_invalid(cfg_invalid),.bus_ok(bus_ok),.diag_irq_en(diag_irq_en),
	.channel_out(channel_out),.channel_led(channel_led),.led_green(led_green),
	.led_red(led_red),.diag_byte0(diag_byte0),.diag_incoming(inc),.diag_going(going),
	.diag_active(act));
task check(input string nm,input logic [15:0] s,e);
	compares++;
	if (s!==e) begin errors++; $display("wrong value %s exp %h saw %h",nm,e,s); end
endtask
task end_sim;
	$display("errors %0d compares %0d",errors,compares);
	if (errors==0 && compares>0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
task t_image;
	check("out",channel_out,16'h0);
	check("led",channel_led,16'h0);
	i_host.wr(1'h0,2'h3,16'ha5c3);
	check("out",channel_out,16'ha5c3);
	i_host.wr(1'h0,2'h1,16'h0f0f);
	check("out",channel_out,16'ha50f);
	i_host.wr(1'h1,2'h3,16'hffff);
	check("led",channel_led,16'ha50f);
	in_rd=1;
	@(negedge clk) check("in",{in_valid,in_rdata},16'h0);
endtask
task t_ovl;
	overload_pin=16'h0010;
	n=0;
	repeat(4) @(negedge clk) n+=inc;
	check("inc",n,16'h1);
	check("red",{led_red,diag_byte0[4],act},16'h7);
	check("diag",diag_byte0,16'h14);
	check("grn",led_green,16'h0);
	overload_pin=16'h0;
	n=0;
	repeat(5) @(negedge clk) n+=going;
	check("going",n,16'h1);
	check("red",led_red,16'h0);
	check("diag",diag_byte0,16'h0);
	check("grn",led_green,16'h1);
	diag_irq_en=0;
	overload_pin=16'h8000;
	n=0;
	m=0;
	repeat(4) @(negedge clk) n+=inc;
	check("inc",n,16'h0);
	check("red",led_red,16'h1);
	overload_pin=16'h0;
	repeat(5) @(negedge clk) m+=going;
	check("going",m,16'h0);
	check("red",led_red,16'h0);
	diag_irq_en=1;
endtask
task t_blink;
	bus_ok=0;
	cfg_invalid=1;
	n=0;
	m=0;
	repeat(4) @(negedge clk);
	repeat(16) @(negedge clk) {n,m}={n+led_green,m+led_red};
	check("grn",n,16'h8);
	check("red",m,16'h8);
	{bus_ok,cfg_invalid}=2'h2;
	repeat(3) @(negedge clk);
	repeat(4) @(negedge clk) check("grn",led_green,16'h1);
endtask
task t_reset;
	i_host.wr(1'h0,2'h2,16'h3cff);
	check("out",channel_out,16'h3c0f);
	rst_n=0;
	repeat(2) @(negedge clk);
	check("out",channel_out,16'h0);
	check("led",channel_led,16'h0);
	rst_n=1;
	@(negedge clk) check("out",channel_out,16'h0);
	i_host.wr(1'h0,2'h3,16'h1234);
	check("out",channel_out,16'h1234);
	check("led",channel_led,16'h1234);
endtask
initial begin repeat(4) @(negedge clk); rst_n=1; t_image; t_ovl; t_blink; t_reset; end_sim; end
initial begin #5000; errors++; end_sim; end
endmodule // sixteen_channel_output_port_tb
